// ==== vpic_pkg.sv ====
package vpic_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int MAX_REQ = 72;
   localparam int FLAG_REGS = 5;
   localparam int PRIO_REGS = 18;
   localparam int TRAP_SRC = 5;
   localparam int EDGE_W = 5;
   localparam logic [ADDR_W-1:0] OFS_GLOBAL_ONE = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_GLOBAL_TWO = 6'h01;
   localparam logic [ADDR_W-1:0] OFS_FLAG0 = 6'h02;
   localparam logic [ADDR_W-1:0] OFS_ENABLE0 = 6'h07;
   localparam logic [ADDR_W-1:0] OFS_PRIO0 = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_PENDING = 6'h1E;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1F;
   localparam logic [ADDR_W-1:0] OFS_CORE = 6'h20;
   localparam int NEST_BIT = 15;
   localparam int ALT_BIT = 15;
   localparam int LEVEL_LSB = 5;
   localparam int LEVEL_MSB_BIT = 3;
   localparam int PEND_LVL_LSB = 8;
   localparam int TRAP_OSC_BIT = 1;
   localparam int TRAP_STACK_BIT = 2;
   localparam int TRAP_ADDR_BIT = 3;
   localparam int TRAP_MATH_BIT = 4;
   localparam int TRAP_DMA_BIT = 5;
   localparam logic [15:0] GLOBAL_ONE_MASK = 16'hFFFE;
   localparam logic [6:0] VECTOR_OFFSET = 7'h08;
   localparam logic [23:0] PRIMARY_BASE = 24'h000004;
   localparam logic [23:0] ALTERNATE_BASE = 24'h000104;
   localparam logic [23:0] ALT_TABLE_END = 24'h0001FE;
   localparam logic [23:0] CODE_START = 24'h000200;
   localparam logic [2:0] LEVEL_BLOCK = 3'h7;
   // Reserved request numbers 15,18,45,57,58,62,63,64,67 masked out
   localparam logic [71:0] IMPL_MASK = 72'hF6_39FF_DFFF_FFFB_7FFF;
   localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage : vpic_pkg

// ==== vpic_ctrl.sv ====
`timescale 1ns/1ns
module vpic_ctrl
#(
   parameter int NUM_REQ = 72
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [vpic_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [vpic_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [vpic_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [NUM_REQ-1:0] src_event,
   input wire logic [vpic_pkg::TRAP_SRC-1:0] trap_event,
   input wire logic core_level_load,
   input wire logic [3:0] core_level_value,
   output logic irq_req,
   output logic [6:0] irq_vector,
   output logic [3:0] irq_level,
   output logic [23:0] irq_vector_addr,
   output logic trap_req,
   output logic [23:0] trap_vector_addr,
   output logic [3:0] cpu_level,
   output logic [vpic_pkg::EDGE_W-1:0] edge_select
);
   import vpic_pkg::*;

   if (NUM_REQ < 1 || NUM_REQ > MAX_REQ)
   begin : g_bad_num
      $error("NUM_REQ must lie between 1 and 72");
   end

   typedef struct packed {
      logic [16*FLAG_REGS-1:0] flag;
      logic [16*FLAG_REGS-1:0] enable;
      logic [3*MAX_REQ-1:0] prio;
      logic [15:0] global_one;
      logic alt;
      logic [EDGE_W-1:0] edge_sel;
      logic [6:0] vec;
      logic [3:0] lvl;
      logic req;
      logic [2:0] cpu_low;
      logic cpu_msb;
      logic [15:0] rdata;
   } vpic_state_type;

   vpic_state_type s;
   vpic_state_type next_s;
   logic [2:0] best_pri;
   logic [6:0] best_idx;
   logic found;
   logic blocked;
   logic take;
   logic [3:0] cur_level;
   logic [ADDR_W-1:0] rel;
   logic [16*FLAG_REGS-1:0] impl_bits;
   // Source priority behind the latched vector, for the level check
   logic [2:0] pend_prio;

   // Both tables share layout, so one base plus twice the vector serves all
   function automatic logic [23:0] table_addr(input logic [6:0] vec, input logic alt);
      logic [23:0] base;
      base = alt ? ALTERNATE_BASE : PRIMARY_BASE;
      table_addr = base + {16'h0000, vec, 1'b0};
   endfunction : table_addr

   // Four sources per priority word, a nibble each, top bit reserved
   function automatic logic [15:0] prio_word(input logic [3*MAX_REQ-1:0] p, input int k);
      logic [15:0] w;
      w = 16'h0000;
      for (int j = 0; j < 4; j++)
      begin
         w[4*j +: 3] = p[3*(4*k+j) +: 3];
      end
      prio_word = w;
   endfunction : prio_word

   assign impl_bits = {8'h00, IMPL_MASK};

   always_comb
   begin
      next_s = s;
      cur_level = {s.cpu_msb, s.cpu_low};
      best_pri = 3'h0;
      best_idx = 7'h00;
      found = 1'b0;
      // Strict compare keeps the lowest request on ties and skips level zero
      for (int i = 0; i < NUM_REQ; i++)
      begin
         if (s.flag[i] && s.enable[i] && IMPL_MASK[i] &&
             s.prio[3*i +: 3] > best_pri)
         begin
            best_pri = s.prio[3*i +: 3];
            best_idx = 7'(i);
            found = 1'b1;
         end
      end
      blocked = s.cpu_msb || (s.cpu_low == LEVEL_BLOCK);
      take = found && !blocked && ({1'b0, best_pri} > cur_level);
      next_s.req = take;
      if (found)
      begin
         next_s.vec = best_idx + VECTOR_OFFSET;
         next_s.lvl = {1'b0, best_pri};
      end
      rel = 6'h00;
      if (reg_wr)
      begin
         if (reg_addr == OFS_GLOBAL_ONE)
         begin
            next_s.global_one = reg_wdata & GLOBAL_ONE_MASK;
         end
         else if (reg_addr == OFS_GLOBAL_TWO)
         begin
            next_s.alt = reg_wdata[ALT_BIT];
            next_s.edge_sel = reg_wdata[EDGE_W-1:0];
         end
         else if (reg_addr >= OFS_FLAG0 && reg_addr < OFS_ENABLE0)
         begin
            rel = reg_addr - OFS_FLAG0;
            next_s.flag[16*rel +: 16] = reg_wdata;
         end
         else if (reg_addr >= OFS_ENABLE0 && reg_addr < OFS_PRIO0)
         begin
            rel = reg_addr - OFS_ENABLE0;
            next_s.enable[16*rel +: 16] = reg_wdata;
         end
         else if (reg_addr >= OFS_PRIO0 && reg_addr < OFS_PENDING)
         begin
            rel = reg_addr - OFS_PRIO0;
            for (int j = 0; j < 4; j++)
            begin
               next_s.prio[3*(4*rel+j) +: 3] = reg_wdata[4*j +: 3];
            end
         end
         else if (reg_addr == OFS_STATUS)
         begin
            if (!s.global_one[NEST_BIT])
            begin
               next_s.cpu_low = reg_wdata[LEVEL_LSB +: 3];
            end
         end
         // Core control and pending writes fall through: MSB stays hardware-owned
      end
      // Hardware set wins over a clearing write in the same cycle
      next_s.flag = next_s.flag | {{(16*FLAG_REGS-NUM_REQ){1'b0}}, src_event};
      next_s.flag = next_s.flag & impl_bits;
      next_s.enable = next_s.enable & impl_bits;
      if (trap_event[0])
      begin
         next_s.global_one[TRAP_OSC_BIT] = 1'b1;
      end
      if (trap_event[1])
      begin
         next_s.global_one[TRAP_ADDR_BIT] = 1'b1;
      end
      if (trap_event[2])
      begin
         next_s.global_one[TRAP_STACK_BIT] = 1'b1;
      end
      if (trap_event[3])
      begin
         next_s.global_one[TRAP_MATH_BIT] = 1'b1;
      end
      if (trap_event[4])
      begin
         next_s.global_one[TRAP_DMA_BIT] = 1'b1;
      end
      // Core entry and return sequencing owns the full level, lock or not
      if (core_level_load)
      begin
         next_s.cpu_low = core_level_value[2:0];
         next_s.cpu_msb = core_level_value[3];
      end
      next_s.rdata = RESET_WORD;
      if (reg_rd)
      begin
         if (reg_addr == OFS_GLOBAL_ONE)
         begin
            next_s.rdata = s.global_one;
         end
         else if (reg_addr == OFS_GLOBAL_TWO)
         begin
            next_s.rdata[ALT_BIT] = s.alt;
            next_s.rdata[EDGE_W-1:0] = s.edge_sel;
         end
         else if (reg_addr >= OFS_FLAG0 && reg_addr < OFS_ENABLE0)
         begin
            next_s.rdata = s.flag[16*(reg_addr - OFS_FLAG0) +: 16];
         end
         else if (reg_addr >= OFS_ENABLE0 && reg_addr < OFS_PRIO0)
         begin
            next_s.rdata = s.enable[16*(reg_addr - OFS_ENABLE0) +: 16];
         end
         else if (reg_addr >= OFS_PRIO0 && reg_addr < OFS_PENDING)
         begin
            next_s.rdata = prio_word(s.prio, int'(reg_addr - OFS_PRIO0));
         end
         else if (reg_addr == OFS_PENDING)
         begin
            next_s.rdata[6:0] = s.vec;
            next_s.rdata[PEND_LVL_LSB +: 4] = s.lvl;
         end
         else if (reg_addr == OFS_STATUS)
         begin
            next_s.rdata[LEVEL_LSB +: 3] = s.cpu_low;
         end
         else if (reg_addr == OFS_CORE)
         begin
            next_s.rdata[LEVEL_MSB_BIT] = s.cpu_msb;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   always_comb
   begin
      trap_vector_addr = table_addr(7'h00, s.alt);
      // Lowest trap vector first: osc, address, stack, math, DMA
      if (s.global_one[TRAP_OSC_BIT])
      begin
         trap_vector_addr = table_addr(7'h01, s.alt);
      end
      else if (s.global_one[TRAP_ADDR_BIT])
      begin
         trap_vector_addr = table_addr(7'h02, s.alt);
      end
      else if (s.global_one[TRAP_STACK_BIT])
      begin
         trap_vector_addr = table_addr(7'h03, s.alt);
      end
      else if (s.global_one[TRAP_MATH_BIT])
      begin
         trap_vector_addr = table_addr(7'h04, s.alt);
      end
      else if (s.global_one[TRAP_DMA_BIT])
      begin
         trap_vector_addr = table_addr(7'h05, s.alt);
      end
   end

   assign trap_req = s.global_one[TRAP_OSC_BIT] | s.global_one[TRAP_ADDR_BIT] |
                     s.global_one[TRAP_STACK_BIT] | s.global_one[TRAP_MATH_BIT] |
                     s.global_one[TRAP_DMA_BIT];
   assign reg_rdata = s.rdata;
   assign irq_req = s.req;
   assign irq_vector = s.vec;
   assign irq_level = s.lvl;
   assign irq_vector_addr = table_addr(s.vec, s.alt);
   assign cpu_level = {s.cpu_msb, s.cpu_low};
   assign pend_prio = s.prio[3*(irq_vector - VECTOR_OFFSET) +: 3];
   assign edge_select = s.edge_sel;

   enable_gate_a: assert property (@(posedge mclk) disable iff (rst)
      take |-> s.enable[best_idx] && s.flag[best_idx])
      else $error("request taken from a disabled or unflagged source");

   zero_prio_a: assert property (@(posedge mclk) disable iff (rst)
      take |-> s.prio[3*best_idx +: 3] != 3'h0)
      else $error("priority zero source raised a request");

   above_level_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req |-> irq_level > $past(cpu_level))
      else $error("request not above the core level");

   level_match_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req && $stable(s.prio) |-> irq_level[2:0] == pend_prio)
      else $error("latched level differs from source priority");

   block_level_a: assert property (@(posedge mclk) disable iff (rst)
      (cpu_level[3] || cpu_level[2:0] == LEVEL_BLOCK) |=> !irq_req)
      else $error("user request while blocked");

   nest_lock_a: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == OFS_STATUS && s.global_one[NEST_BIT] && !core_level_load
      |=> $stable(cpu_level[2:0]))
      else $error("priority changed while nesting disabled");

   msb_readonly_a: assert property (@(posedge mclk) disable iff (rst)
      !core_level_load |=> $stable(cpu_level[3]))
      else $error("priority MSB changed by software");

   flag_sticky_a: assert property (@(posedge mclk) disable iff (rst)
      (src_event[0] || (s.flag[0] && !reg_wr)) |=> s.flag[0])
      else $error("request flag lost");

   table_range_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req |-> irq_vector_addr <= ALT_TABLE_END && irq_vector_addr < CODE_START)
      else $error("vector address beyond the tables");

   read_lag_a: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && reg_addr == OFS_PENDING |=> reg_rdata[6:0] == $past(s.vec))
      else $error("pending register read mismatch");

   trap_sticky_a: assert property (@(posedge mclk) disable iff (rst)
      trap_event != 5'h00 |=> trap_req)
      else $error("trap event lost");

   vector_range_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req |-> irq_vector >= VECTOR_OFFSET && irq_vector < VECTOR_OFFSET + 7'(NUM_REQ))
      else $error("vector outside the request range");

   reserved_src_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req |-> IMPL_MASK[irq_vector - VECTOR_OFFSET])
      else $error("reserved request raised");

   // Address bit 8 alone tells the two tables apart
   table_select_a: assert property (@(posedge mclk) disable iff (rst)
      irq_vector_addr[8] == s.alt && trap_vector_addr[8] == s.alt)
      else $error("vector fetched from the wrong table");

   rdata_idle_a: assert property (@(posedge mclk) disable iff (rst)
      !reg_rd |=> reg_rdata == RESET_WORD)
      else $error("read data outside its slot");

   unmapped_zero_a: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && reg_addr > OFS_CORE |=> reg_rdata == RESET_WORD)
      else $error("unmapped read not zero");

   enable_write_a: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == OFS_ENABLE0 |=> s.enable[15:0] == ($past(reg_wdata) & IMPL_MASK[15:0]))
      else $error("enable write lost");

   prio_write_a: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == OFS_PRIO0 |=> s.prio[2:0] == $past(reg_wdata[2:0]))
      else $error("priority write lost");

   status_write_a: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == OFS_STATUS && !s.global_one[NEST_BIT] && !core_level_load
      |=> cpu_level[2:0] == $past(reg_wdata[LEVEL_LSB +: 3]))
      else $error("status level write lost");

   core_load_a: assert property (@(posedge mclk) disable iff (rst)
      core_level_load |=> cpu_level == $past(core_level_value))
      else $error("core level load lost");

   pending_hold_a: assert property (@(posedge mclk) disable iff (rst)
      !found |=> $stable(irq_vector) && $stable(irq_level))
      else $error("pending register moved with nothing pending");

   flag_clear_a: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == OFS_FLAG0 && !reg_wdata[0] && !src_event[0] |=> !s.flag[0])
      else $error("flag clear ignored");

   trap_osc_a: assert property (@(posedge mclk) disable iff (rst)
      s.global_one[TRAP_OSC_BIT] |-> trap_vector_addr[7:0] == 8'h06)
      else $error("oscillator trap vector wrong");

   edge_write_a: assert property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == OFS_GLOBAL_TWO |=> edge_select == $past(reg_wdata[EDGE_W-1:0]))
      else $error("edge select write lost");

   nonzero_level_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req |-> irq_level != 4'h0)
      else $error("request with level zero");

   irq_cov: cover property (@(posedge mclk) disable iff (rst) irq_req);
   alt_cov: cover property (@(posedge mclk) disable iff (rst) irq_req && s.alt);
   trap_cov: cover property (@(posedge mclk) disable iff (rst) trap_req);
   nest_cov: cover property (@(posedge mclk) disable iff (rst)
      reg_wr && reg_addr == OFS_STATUS && s.global_one[NEST_BIT]);
   tie_cov: cover property (@(posedge mclk) disable iff (rst) irq_req && irq_vector == VECTOR_OFFSET);
endmodule : vpic_ctrl

// ==== vpic_core_model.sv ====
`timescale 1ns/1ns
module vpic_core_model
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic irq_req,
   input wire logic [3:0] irq_level,
   input wire logic take_en,
   input wire logic [3:0] take_delay,
   input wire logic set_go,
   input wire logic [3:0] set_val,
   output logic core_level_load,
   output logic [3:0] core_level_value
);
   logic [3:0] cnt;

   // Accepting an interrupt raises the core level to the new level
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cnt <= 4'h0;
         core_level_load <= 1'b0;
         core_level_value <= 4'h0;
      end
      else
      begin
         core_level_load <= 1'b0;
         if (set_go)
         begin
            core_level_load <= 1'b1;
            core_level_value <= set_val;
         end
         else if (take_en && irq_req && !core_level_load)
         begin
            if (cnt == take_delay)
            begin
               cnt <= 4'h0;
               core_level_load <= 1'b1;
               core_level_value <= irq_level;
            end
            else
               cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : vpic_core_model

// ==== tb_vpic_ctrl.sv ====
`timescale 1ns/1ns
module tb_vpic_ctrl;
   import vpic_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [71:0] src_event = '0;
   logic [TRAP_SRC-1:0] trap_event = '0;
   logic core_level_load;
   logic [3:0] core_level_value;
   logic irq_req, trap_req, take_en = 1'b0, set_go = 1'b0;
   logic [6:0] irq_vector;
   logic [3:0] irq_level, cpu_level, set_val = 4'h0;
   logic [23:0] irq_vector_addr, trap_vector_addr;
   logic [EDGE_W-1:0] edge_select;
   int errors = 0;
   int n_checks = 0;

   always #5 mclk = ~mclk;

   vpic_ctrl dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
      .trap_event(trap_event), .core_level_load(core_level_load),
      .core_level_value(core_level_value), .irq_req(irq_req), .irq_vector(irq_vector),
      .irq_level(irq_level), .irq_vector_addr(irq_vector_addr), .trap_req(trap_req),
      .trap_vector_addr(trap_vector_addr), .cpu_level(cpu_level), .edge_select(edge_select));

   vpic_core_model core (.mclk(mclk), .rst(rst), .irq_req(irq_req), .irq_level(irq_level),
      .take_en(take_en), .take_delay(4'h3), .set_go(set_go), .set_val(set_val),
      .core_level_load(core_level_load), .core_level_value(core_level_value));

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask : chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
   endtask : rd

   task automatic ev(input int n);
      @(posedge mclk);
      src_event[n] <= 1'b1;
      @(posedge mclk);
      src_event[n] <= 1'b0;
   endtask : ev

   task automatic lvl(input logic [3:0] v);
      @(posedge mclk);
      set_go <= 1'b1;
      set_val <= v;
      @(posedge mclk);
      set_go <= 1'b0;
   endtask : lvl

   // Interrupt path answers two cycles after its cause: the state register first, then the request
   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask : settle

   task automatic wait_irq(input logic exp);
      int i;
      i = 0;
      while (irq_req !== exp && i < 20)
      begin
         @(posedge mclk);
         #1;
         i++;
      end
      chk("irq_req", {23'h0, exp}, {23'h0, irq_req});
      if (irq_req !== exp)
         wrap_up();
   endtask : wait_irq

   task automatic irq_is(input logic r, input logic [6:0] v, input logic [23:0] a);
      chk("irq_req", {23'h0, r}, {23'h0, irq_req});
      chk("irq_vector", {17'h0, v}, {17'h0, irq_vector});
      chk("irq_vector_addr", a, irq_vector_addr);
   endtask : irq_is

   initial
   begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++)
         rd(i < 6 ? OFS_FLAG0 + 6'(5 * i) : 6'h21, 16'h0000);
      rd(OFS_PENDING, 16'h0000);
      wr(OFS_ENABLE0, 16'h0009);
      wr(OFS_PRIO0, 16'h5005);
      rd(OFS_ENABLE0, 16'h0009);
      ev(3);
      wait_irq(1'b1);
      irq_is(1'b1, 7'h0B, 24'h00001A);
      chk("irq_level", 24'h5, {20'h0, irq_level});
      rd(OFS_PENDING, 16'h050B);
      ev(0);
      settle();
      irq_is(1'b1, 7'h08, 24'h000014);
      wr(OFS_GLOBAL_TWO, 16'h8015);
      settle();
      irq_is(1'b1, 7'h08, 24'h000114);
      chk("edge_select", 24'h15, {19'h0, edge_select});
      rd(OFS_GLOBAL_TWO, 16'h8015);
      wr(OFS_GLOBAL_TWO, 16'h0000);
      wr(OFS_FLAG0, 16'h0008);
      settle();
      irq_is(1'b1, 7'h0B, 24'h00001A);
      wr(OFS_ENABLE0, 16'h0001);
      settle();
      chk("irq_req", 24'h0, {23'h0, irq_req});
      wr(OFS_ENABLE0, 16'h0009);
      wr(OFS_STATUS, 16'h00A0);
      settle();
      chk("irq_req", 24'h0, {23'h0, irq_req});
      wr(OFS_STATUS, 16'h0080);
      wait_irq(1'b1);
      wr(OFS_GLOBAL_ONE, 16'h8000);
      wr(OFS_STATUS, 16'h00E0);
      rd(OFS_STATUS, 16'h0080);
      wr(OFS_GLOBAL_ONE, 16'h0000);
      wr(OFS_CORE, 16'h0008);
      rd(OFS_CORE, 16'h0000);
      @(posedge mclk);
      take_en <= 1'b1;
      wait_irq(1'b0);
      chk("cpu_level", 24'h5, {20'h0, cpu_level});
      @(posedge mclk);
      take_en <= 1'b0;
      rd(OFS_STATUS, 16'h00A0);
      lvl(4'h8);
      wr(OFS_PRIO0, 16'h7005);
      settle();
      chk("cpu_level", 24'h8, {20'h0, cpu_level});
      chk("irq_req", 24'h0, {23'h0, irq_req});
      rd(OFS_CORE, 16'h0008);
      lvl(4'h7);
      settle();
      chk("irq_req", 24'h0, {23'h0, irq_req});
      lvl(4'h0);
      wait_irq(1'b1);
      chk("irq_level", 24'h7, {20'h0, irq_level});
      wr(OFS_FLAG0, 16'h0000);
      wr(OFS_ENABLE0, 16'h0002);
      wr(OFS_PRIO0, 16'h0000);
      ev(1);
      ev(15);
      settle();
      chk("irq_req", 24'h0, {23'h0, irq_req});
      rd(OFS_FLAG0, 16'h0002);
      wr(OFS_ENABLE0 + 6'h04, 16'h0080);
      wr(OFS_PRIO0 + 6'h11, 16'h3000);
      ev(71);
      wait_irq(1'b1);
      irq_is(1'b1, 7'h4F, 24'h0000A2);
      rd(OFS_FLAG0 + 6'h04, 16'h0080);
      @(posedge mclk);
      trap_event[1] <= 1'b1;
      @(posedge mclk);
      trap_event[1] <= 1'b0;
      settle();
      chk("trap_req", 24'h1, {23'h0, trap_req});
      chk("trap_vector_addr", 24'h000008, trap_vector_addr);
      rd(OFS_GLOBAL_ONE, 16'h0008);
      @(posedge mclk);
      trap_event <= 5'h1D;
      @(posedge mclk);
      trap_event <= 5'h00;
      settle();
      rd(OFS_GLOBAL_ONE, 16'h003E);
      chk("trap_vector_addr", 24'h000006, trap_vector_addr);
      wr(OFS_GLOBAL_TWO, 16'h8000);
      settle();
      chk("trap_vector_addr", 24'h000106, trap_vector_addr);
      wr(OFS_GLOBAL_ONE, 16'h0000);
      settle();
      chk("trap_req", 24'h0, {23'h0, trap_req});
      wrap_up();
   end
endmodule : tb_vpic_ctrl
